// file: design/sdf_card_port.sv
`timescale 1ns/1ps
`include "sdf_regs.svh"
module sdf_card_port (
  input  wire logic            clock_in,
  input  wire logic            resetn_in,
  input  sdf_pkg::sdf_pins_in_t pins_in,
  output sdf_pkg::sdf_pins_out_t pins_out,
  input  sdf_pkg::sdf_mode_t   mode_in,
  input  wire logic            irq_req_in,
  input  wire logic            oob_irq_en_in,
  input  wire logic            read_wait_in,
  input  wire logic            clk_force_in,
  output logic                 gpio_irq_out,
  output logic                 if_clk_en_out,
  output sdf_pkg::sdf_cmd_t    cmd_out,
  output logic                 cmd_valid_out,
  output logic                 size_err_out,
  output logic                 overrun_out,
  output logic           [7:0] rx_data_out,
  output logic                 rx_valid_out,
  input  wire logic            rx_ready_in
);
  import sdf_pkg::*;

  sdf_pins_in_t  pins_s;
  logic          clk_d;
  logic          rise;
  logic          cs_n;
  logic          spi;
  sdf_state_t    state;
  sdf_state_t    next_state;
  logic [47:0]   sh;
  logic [47:0]   next_sh;
  logic [5:0]    bitcnt;
  logic [5:0]    next_bitcnt;
  logic [7:0]    byte_sh;
  logic [7:0]    next_byte_sh;
  logic [3:0]    nbits;
  logic [3:0]    next_nbits;
  logic [9:0]    bytecnt;
  logic [9:0]    next_bytecnt;
  logic [4:0]    crccnt;
  logic [4:0]    next_crccnt;
  logic          hold_valid;
  logic          next_hold_valid;
  logic [7:0]    hold_byte;
  logic [7:0]    next_hold_byte;
  logic          fifo_ready;
  sdf_cmd_t      next_cmd;
  logic          next_cmd_valid;
  logic          next_size_err;
  logic          next_overrun;
  logic [7:0]    idle_cnt;
  logic [7:0]    next_idle_cnt;
  logic          next_clk_en;
  logic          next_gpio_irq;
  sdf_pins_out_t next_pins;
  logic [47:0]   frame;
  logic [31:0]   arg;
  logic          frame_ok;
  logic          over;
  logic [3:0]    wide_bits;
  logic [7:0]    wide_byte;
  logic          data_busy;

  sdf_sync #(
    .W (6)
  ) u_sync (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .d_in      (pins_in),
    .q_out     (pins_s)
  );

  // Received bytes wait in the holding register while the buffer is full
  sdf_fifo #(
    .W (8),
    .D (4)
  ) u_fifo (
    .clock_in      (clock_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (hold_valid),
    .in_data_in    (hold_byte),
    .in_ready_out  (fifo_ready),
    .out_valid_out (rx_valid_out),
    .out_data_out  (rx_data_out),
    .out_ready_in  (rx_ready_in)
  );

  function automatic logic size_over(input logic [2:0] f, input logic [9:0] n);
    logic r;
    r = 1'b1;
    unique case (f)
      3'h0: r = (n > `SDF_F0_MAX);
      3'h1: r = (n > `SDF_F1_MAX);
      3'h2: r = (n > `SDF_F2_MAX);
      default: r = 1'b1;
    endcase
    return r;
  endfunction

  always_comb
  begin
    rise      = pins_s.clk && !clk_d;
    spi       = (mode_in == SDF_MODE_SPI);
    cs_n      = pins_s.dat[3];
    frame     = {sh[46:0], pins_s.cmd};
    arg       = spi ? frame[31:0] : frame[39:8];
    frame_ok  = spi || (frame[46] && frame[0] && frame[45:40] == `SDF_IDX_RW_EXT);
    over      = size_over(arg[30:28], (arg[8:0] == 9'h000) ? `SDF_F2_MAX : {1'b0, arg[8:0]});
    // four lines per clock in 4-bit mode, one line otherwise
    wide_bits = (mode_in == SDF_MODE_SD4) ? nbits + 4'h4 : nbits + 4'h1;
    wide_byte = (mode_in == SDF_MODE_SD4) ? {byte_sh[3:0], pins_s.dat}
                                          : {byte_sh[6:0], pins_s.dat[0]};
    data_busy = (state == SDF_ST_DSTART) || (state == SDF_ST_DATA) || (state == SDF_ST_CRC);
  end

  always_comb
  begin
    next_state      = state;
    next_sh         = sh;
    next_bitcnt     = bitcnt;
    next_byte_sh    = byte_sh;
    next_nbits      = nbits;
    next_bytecnt    = bytecnt;
    next_crccnt     = crccnt;
    next_hold_byte  = hold_byte;
    next_cmd        = cmd_out;
    next_cmd_valid  = 1'b0;
    next_size_err   = size_err_out;
    next_overrun    = overrun_out;
    next_hold_valid = hold_valid && !fifo_ready;
    unique case (state)
      SDF_ST_IDLE:
      begin
        if (rise && (spi ? !cs_n : !pins_s.cmd))
        begin
          next_sh       = frame;
          next_bitcnt   = 6'h01;
          next_size_err = 1'b0;
          next_overrun  = 1'b0;
          next_state    = SDF_ST_CMD;
        end
      end
      SDF_ST_CMD:
      begin
        if (spi && cs_n)
        begin
          next_state = SDF_ST_IDLE;
        end
        else if (rise)
        begin
          next_sh     = frame;
          next_bitcnt = bitcnt + 6'h01;
          if (next_bitcnt == (spi ? `SDF_SPI_BITS : `SDF_CMD_BITS))
          begin
            next_state = SDF_ST_IDLE;
            if (frame_ok)
            begin
              next_cmd.write = arg[31];
              next_cmd.func  = arg[30:28];
              next_cmd.count = (arg[8:0] == 9'h000) ? `SDF_F2_MAX : {1'b0, arg[8:0]};
              next_cmd_valid = 1'b1;
              next_size_err  = over;
              if (arg[31] && !over && !spi)
              begin
                next_state = SDF_ST_DSTART;
              end
            end
          end
        end
      end
      SDF_ST_DSTART:
      begin
        if (rise && !pins_s.dat[0])
        begin
          next_bytecnt = '0;
          next_nbits   = '0;
          next_state   = SDF_ST_DATA;
        end
      end
      SDF_ST_DATA:
      begin
        if (rise)
        begin
          next_byte_sh = wide_byte;
          next_nbits   = wide_bits;
          if (wide_bits == `SDF_BYTE_BITS)
          begin
            next_nbits = '0;
            // Held byte is overwritten but flagged, a full buffer never stops the host clock
            if (hold_valid && !fifo_ready)
            begin
              next_overrun = 1'b1;
            end
            next_hold_valid = 1'b1;
            next_hold_byte  = wide_byte;
            next_bytecnt    = bytecnt + 10'h001;
            if (next_bytecnt == cmd_out.count)
            begin
              next_crccnt = '0;
              next_state  = SDF_ST_CRC;
            end
          end
        end
      end
      SDF_ST_CRC:
      begin
        if (rise)
        begin
          next_crccnt = crccnt + 5'h01;
          if (next_crccnt == `SDF_CRC_BITS)
          begin
            next_state = SDF_ST_BUSY;
          end
        end
      end
      SDF_ST_BUSY:
      begin
        if (!hold_valid)
        begin
          next_state = SDF_ST_IDLE;
        end
      end
    endcase
  end

  always_comb
  begin
    next_pins = '0;
    // gated clock held on by force or link activity
    next_idle_cnt = rise ? `SDF_IDLE_CYC : ((idle_cnt != '0) ? idle_cnt - 8'h01 : idle_cnt);
    next_clk_en   = clk_force_in || (next_idle_cnt != '0);
    // interrupt mirrored on the general-purpose pin
    next_gpio_irq = oob_irq_en_in && irq_req_in;
    if (spi)
    begin
      // line zero is serial out while selected
      next_pins.dat_oe[0] = !cs_n;
      next_pins.dat_o[0]  = !size_err_out;
      next_pins.dat_oe[1] = irq_req_in;
    end
    else
    begin
      // Busy on line zero is the back-pressure the host sees
      next_pins.dat_oe[0] = (state == SDF_ST_BUSY);
      // interrupt only outside data in 4-bit
      next_pins.dat_oe[1] = irq_req_in && ((mode_in == SDF_MODE_SD1) || !data_busy);
      // read-wait only outside data in 4-bit
      next_pins.dat_oe[2] = read_wait_in && ((mode_in == SDF_MODE_SD1) || !data_busy);
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      clk_d         <= 1'b1;
      state         <= SDF_ST_IDLE;
      sh            <= '1;
      bitcnt        <= '0;
      byte_sh       <= '0;
      nbits         <= '0;
      bytecnt       <= '0;
      crccnt        <= '0;
      hold_valid    <= 1'b0;
      hold_byte     <= '0;
      cmd_out       <= '0;
      cmd_valid_out <= 1'b0;
      size_err_out  <= 1'b0;
      overrun_out   <= 1'b0;
      idle_cnt      <= '0;
      if_clk_en_out <= 1'b0;
      gpio_irq_out  <= 1'b0;
      pins_out      <= '0;
    end
    else
    begin
      clk_d         <= pins_s.clk;
      state         <= next_state;
      sh            <= next_sh;
      bitcnt        <= next_bitcnt;
      byte_sh       <= next_byte_sh;
      nbits         <= next_nbits;
      bytecnt       <= next_bytecnt;
      crccnt        <= next_crccnt;
      hold_valid    <= next_hold_valid;
      hold_byte     <= next_hold_byte;
      cmd_out       <= next_cmd;
      cmd_valid_out <= next_cmd_valid;
      size_err_out  <= next_size_err;
      overrun_out   <= next_overrun;
      idle_cnt      <= next_idle_cnt;
      if_clk_en_out <= next_clk_en;
      gpio_irq_out  <= next_gpio_irq;
      pins_out      <= next_pins;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  sequence s_spi_sel;
    mode_in == SDF_MODE_SPI && !cs_n;
  endsequence

  sequence s_write_go;
    cmd_valid_out && cmd_out.write && !size_err_out && mode_in != SDF_MODE_SPI;
  endsequence

  a_f0_limit: assert property (
    cmd_valid_out && cmd_out.func == 3'h0 && cmd_out.count > 10'h020 |-> size_err_out)
    else $error("function 0 oversize accepted");
  a_f1_limit: assert property (
    cmd_valid_out && cmd_out.func == 3'h1 |-> size_err_out == (cmd_out.count > 10'h040))
    else $error("function 1 limit wrong");
  a_f2_write: assert property (
    s_write_go |-> cmd_out.count <= 10'h200 && state == SDF_ST_DSTART)
    else $error("accepted write did not enter data phase");
  a_irq_one_bit: assert property (
    mode_in == SDF_MODE_SD1 && irq_req_in |=> pins_out.dat_oe[1] && !pins_out.dat_o[1])
    else $error("interrupt not driven in 1-bit mode");
  a_data_no_irq: assert property (
    mode_in == SDF_MODE_SD4 && state == SDF_ST_DATA |=> !pins_out.dat_oe[1])
    else $error("interrupt driven over 4-bit data");
  a_rwait_data: assert property (
    mode_in == SDF_MODE_SD4 && state == SDF_ST_DATA ##1 1'b1 |-> !pins_out.dat_oe[2])
    else $error("read-wait driven over 4-bit data");
  a_dat3_unused: assert property (
    mode_in == SDF_MODE_SD1 |=> !pins_out.dat_oe[3])
    else $error("line three driven in 1-bit mode");
  a_spi_output: assert property (
    s_spi_sel |=> pins_out.dat_oe[0] && !pins_out.dat_oe[2])
    else $error("serial output not driven while selected");
  a_oob_irq: assert property (
    oob_irq_en_in && irq_req_in |=> gpio_irq_out)
    else $error("out-of-band interrupt missing");
  a_clk_force: assert property (
    clk_force_in |=> if_clk_en_out)
    else $error("forced clock not enabled");
  a_busy_hold: assert property (
    state == SDF_ST_BUSY && hold_valid |=> state == SDF_ST_BUSY ##1 pins_out.dat_oe[0])
    else $error("busy released with byte pending");
endmodule

// file: design/sdf_fifo.sv
`timescale 1ns/1ps
module sdf_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         clock_in,
  input  wire logic         resetn_in,
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  output logic              out_valid_out,
  output logic      [W-1:0] out_data_out,
  input  wire logic         out_ready_in
);
  localparam int PW = $clog2(D);

  // Depth must be a power of two so the pointers wrap by themselves
  logic [W-1:0] mem [D];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0]   cnt;
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [PW:0]   next_cnt;
  logic          next_out_valid;
  logic [W-1:0]  next_out_data;
  logic          push;
  logic          load;

  always_comb
  begin
    in_ready_out   = (cnt < (PW+1)'(D));
    push           = in_valid_in && in_ready_out;
    load           = (cnt != '0) && (!out_valid_out || out_ready_in);
    next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr    = load ? rd_ptr + 1'b1 : rd_ptr;
    next_cnt       = cnt + (PW+1)'(push) - (PW+1)'(load);
    next_out_data  = load ? mem[rd_ptr] : out_data_out;
    next_out_valid = load ? 1'b1 : (out_valid_out && !out_ready_in);
  end

  always_ff @(posedge clock_in)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      wr_ptr        <= '0;
      rd_ptr        <= '0;
      cnt           <= '0;
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end
    else
    begin
      wr_ptr        <= next_wr_ptr;
      rd_ptr        <= next_rd_ptr;
      cnt           <= next_cnt;
      out_valid_out <= next_out_valid;
      out_data_out  <= next_out_data;
    end
  end
endmodule

// file: design/sdf_sync.sv
`timescale 1ns/1ps
module sdf_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_in,
  input  wire logic         resetn_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb
  begin
    next_meta = d_in;
    next_q    = meta;
  end

  // Pins idle high, so reset to ones avoids a false start bit
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      meta  <= '1;
      q_out <= '1;
    end
    else
    begin
      meta  <= next_meta;
      q_out <= next_q;
    end
  end
endmodule

// file: pkg/sdf_pkg.sv
package sdf_pkg;
  typedef enum logic [2:0]
  {
    SDF_MODE_SD1 = 3'b001,
    SDF_MODE_SD4 = 3'b010,
    SDF_MODE_SPI = 3'b100
  } sdf_mode_t;

  typedef enum logic [5:0]
  {
    SDF_ST_IDLE   = 6'b000001,
    SDF_ST_CMD    = 6'b000010,
    SDF_ST_DSTART = 6'b000100,
    SDF_ST_DATA   = 6'b001000,
    SDF_ST_CRC    = 6'b010000,
    SDF_ST_BUSY   = 6'b100000
  } sdf_state_t;

  typedef struct packed
  {
    logic       clk;
    logic       cmd;
    logic [3:0] dat;
  } sdf_pins_in_t;

  typedef struct packed
  {
    logic       cmd_o;
    logic       cmd_oe;
    logic [3:0] dat_o;
    logic [3:0] dat_oe;
  } sdf_pins_out_t;

  typedef struct packed
  {
    logic       write;
    logic [2:0] func;
    logic [9:0] count;
  } sdf_cmd_t;
endpackage

// file: pkg/sdf_regs.svh
`ifndef SDF_REGS_SVH
`define SDF_REGS_SVH
`define SDF_CLK_NS      5
`define SDF_CMD_BITS    6'h30
`define SDF_SPI_BITS    6'h20
`define SDF_IDX_RW_EXT  6'h35
`define SDF_F0_MAX      10'h020
`define SDF_F1_MAX      10'h040
`define SDF_F2_MAX      10'h200
`define SDF_CRC_BITS    5'h11
`define SDF_BYTE_BITS   4'h8
`define SDF_IDLE_NS     1000
`define SDF_IDLE_CYC    8'(`SDF_IDLE_NS / `SDF_CLK_NS)
`endif

// file: testbench/sdf_card_port_bench.sv
`timescale 1ns/1ps
module sdf_card_port_bench;
  import sdf_pkg::*;
  logic          clock_in;
  logic          resetn_in;
  sdf_pins_in_t  pins_in;
  sdf_pins_out_t pins_out;
  sdf_mode_t     mode_in;
  logic          irq_req_in;
  logic          oob_irq_en_in;
  logic          read_wait_in;
  logic          clk_force_in;
  logic          rx_ready_in = 1'b1;
  logic          gpio_irq_out;
  logic          if_clk_en_out;
  sdf_cmd_t      cmd_out;
  logic          cmd_valid_out;
  logic          size_err_out;
  logic          overrun_out;
  logic [7:0]    rx_data_out;
  logic          rx_valid_out;
  logic          hclk;
  logic          hcmd;
  logic [3:0]    hdat;
  logic [3:0]    hen;
  logic [3:0]    dat_lvl;
  logic [1:0]    smode = 2'd2;
  logic [31:0]   rng = 32'h60;
  logic [31:0]   sk = 32'h60;
  int            fail_count = 0;
  int            total_checks = 0;
  sdf_cmd_t      cap_q[$];
  logic [7:0]    rx_q[$];
  logic [7:0]    exp_q[$];
  sdf_cmd_t      tab[5] = '{'{1, 0, 33}, '{1, 1, 65}, '{1, 3, 1}, '{1, 1, 512}, '{0, 2, 512}};

  // Pull-ups: a released line reads high
  assign dat_lvl = (pins_out.dat_oe & pins_out.dat_o) | (~pins_out.dat_oe & (~hen | hdat));
  assign pins_in = '{clk: hclk, cmd: pins_out.cmd_oe ? pins_out.cmd_o : hcmd, dat: dat_lvl};

  sdf_card_port dut (.clock_in(clock_in), .resetn_in(resetn_in), .pins_in(pins_in),
    .pins_out(pins_out), .mode_in(mode_in), .irq_req_in(irq_req_in),
    .oob_irq_en_in(oob_irq_en_in), .read_wait_in(read_wait_in), .clk_force_in(clk_force_in),
    .gpio_irq_out(gpio_irq_out), .if_clk_en_out(if_clk_en_out), .cmd_out(cmd_out),
    .cmd_valid_out(cmd_valid_out), .size_err_out(size_err_out), .overrun_out(overrun_out),
    .rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out), .rx_ready_in(rx_ready_in));
  sdf_host_model host (.lclk_out(hclk), .cmd_out(hcmd), .dat_out(hdat), .dat_en_out(hen));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic int lim(input logic [2:0] f);
    return (f == 3'h0) ? 32 : (f == 3'h1) ? 64 : 512;
  endfunction

  initial
  begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end

  // Sink: stalled, random or always ready
  always @(posedge clock_in)
  begin
    sk <= xs(sk);
    rx_ready_in <= (smode == 2'd2) | ((smode == 2'd1) & sk[3]);
    if (cmd_valid_out === 1'b1)
      cap_q.push_back(cmd_out);
    if (rx_valid_out === 1'b1 && rx_ready_in === 1'b1)
      rx_q.push_back(rx_data_out);
  end

  task automatic rep(input logic [15:0] g, input logic [15:0] e, input logic bad);
    total_checks++;
    if (bad)
    begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    rep(16'(g), 16'(e), g !== e);
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    rep(16'(g), 16'(e), g !== e);
  endtask
  task automatic chk_cmd(input sdf_cmd_t g, input sdf_cmd_t e);
    rep(16'(g), 16'(e), g !== e);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic do_cmd(input logic w, input logic [2:0] f, input int c, input logic spi);
    logic [31:0] arg;
    sdf_cmd_t    e;
    int          n;
    arg = {w, f, 19'h0, c[8:0]};
    e = '{write: w, func: f, count: (c[8:0] == 9'h0) ? 10'h200 : {1'b0, c[8:0]}};
    if (spi)
      host.spi_cmd(arg);
    else
      host.send_cmd(6'h35, arg);
    n = 0;
    while (cap_q.size() == 0 && n < 40)
    begin
      @(posedge clock_in);
      n++;
    end
    if (cap_q.size() == 0)
      chk_bit(1'b0, 1'b1);
    else
      chk_cmd(cap_q.pop_front(), e);
    chk_bit(size_err_out, w & (f > 3'h2 || e.count > lim(f)));
    chk_bit(overrun_out, 1'b0);
  endtask

  task automatic xfer(input logic [2:0] f, input int n, input logic four, input logic ovr);
    logic [7:0] d[$];
    do_cmd(1'b1, f, n, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      rng = xs(rng);
      d.push_back(rng[7:0]);
      // A byte landing on a full holding register replaces it
      if (!ovr || i != n - 2)
        exp_q.push_back(rng[7:0]);
    end
    host.send_data(d, four);
  endtask

  task automatic drain();
    int n;
    n = 0;
    repeat (8) @(posedge clock_in);
    while (pins_out.dat_oe[0] === 1'b1 && n < 4000)
    begin
      @(posedge clock_in);
      n++;
    end
    repeat (10) @(posedge clock_in);
    while (exp_q.size() > 0)
      if (rx_q.size() == 0)
        chk_byte(8'h0, exp_q.pop_front());
      else
        chk_byte(rx_q.pop_front(), exp_q.pop_front());
    chk_bit(rx_q.size() == 0 && n < 4000, 1'b1);
  endtask

  task automatic setin(input sdf_mode_t m, input logic irq, input logic rw, input logic [1:0] s);
    @(posedge clock_in);
    mode_in <= m;
    irq_req_in <= irq;
    read_wait_in <= rw;
    smode <= s;
    repeat (3) @(posedge clock_in);
  endtask

  initial
  begin
    #300000;
    fail_count++;
    end_sim();
  end

  initial
  begin
    resetn_in = 1'b0;
    mode_in = SDF_MODE_SD1;
    irq_req_in = 1'b0;
    oob_irq_en_in = 1'b0;
    read_wait_in = 1'b0;
    clk_force_in = 1'b0;
    repeat (8) @(posedge clock_in);
    resetn_in <= 1'b1;
    repeat (20) @(posedge clock_in);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock_in);
      oob_irq_en_in <= i[0];
      irq_req_in <= i[1];
      repeat (3) @(posedge clock_in);
      chk_bit(gpio_irq_out, i[0] & i[1]);
    end
    setin(SDF_MODE_SD1, 1'b1, 1'b1, 2'd2);
    chk_byte({4'h0, pins_out.dat_oe}, 8'h06);
    setin(SDF_MODE_SD4, 1'b1, 1'b1, 2'd2);
    chk_byte({4'h0, pins_out.dat_oe | pins_out.dat_o}, 8'h06);
    $display("pins done");
    repeat (200) @(posedge clock_in);
    chk_bit(if_clk_en_out, 1'b0);
    clk_force_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    chk_bit(if_clk_en_out, 1'b1);
    clk_force_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    chk_bit(if_clk_en_out, 1'b0);
    $display("clock force done");
    setin(SDF_MODE_SD1, 1'b0, 1'b0, 2'd1);
    foreach (tab[i])
      do_cmd(tab[i].write, tab[i].func, int'(tab[i].count), 1'b0);
    host.send_cmd(6'h34, 32'h8000_0001);
    repeat (10) @(posedge clock_in);
    chk_bit(cap_q.size() == 0, 1'b1);
    xfer(3'h0, 32, 1'b0, 1'b0);
    drain();
    $display("size limits done");
    setin(SDF_MODE_SD4, 1'b1, 1'b1, 2'd1);
    fork
      xfer(3'h1, 64, 1'b1, 1'b0);
      begin
        repeat (1200) @(posedge clock_in);
        chk_byte({4'h0, pins_out.dat_oe}, 8'h00);
        chk_bit(if_clk_en_out, 1'b1);
      end
    join
    setin(SDF_MODE_SD4, 1'b0, 1'b0, 2'd1);
    drain();
    xfer(3'h2, 512, 1'b1, 1'b0);
    drain();
    $display("four bit done");
    // Stalled sink holds five bytes in the buffer and one in the holding register
    for (int k = 6; k < 8; k++)
    begin
      setin(SDF_MODE_SD1, 1'b0, 1'b0, 2'd0);
      xfer(3'h0, k, 1'b0, k == 7);
      repeat (10) @(posedge clock_in);
      chk_bit(pins_out.dat_oe[0] & ~pins_out.dat_o[0], 1'b1);
      chk_bit(overrun_out, k == 7);
      setin(SDF_MODE_SD1, 1'b0, 1'b0, 2'd2);
      drain();
    end
    $display("fill done");
    setin(SDF_MODE_SPI, 1'b1, 1'b0, 2'd2);
    fork
      do_cmd(1'b1, 3'h2, 100, 1'b1);
      begin
        repeat (200) @(posedge clock_in);
        chk_byte({4'h0, pins_out.dat_oe}, 8'h03);
        chk_bit(pins_out.dat_o[0], 1'b1);
      end
    join
    repeat (10) @(posedge clock_in);
    chk_byte({4'h0, pins_out.dat_oe}, 8'h02);
    $display("spi done");
    end_sim();
  end
endmodule

// file: testbench/sdf_host_model.sv
`timescale 1ns/1ps
module sdf_host_model (
  output logic       lclk_out,
  output logic       cmd_out,
  output logic [3:0] dat_out,
  output logic [3:0] dat_en_out
);
  initial
  begin
    lclk_out   = 1'b0;
    cmd_out    = 1'b1;
    dat_out    = 4'hf;
    dat_en_out = 4'h0;
  end

  // slow link clock
  // Stands still between frames, so idle detection is exercised
  task automatic tick();
    #40 lclk_out = 1'b1;
    #40 lclk_out = 1'b0;
  endtask

  task automatic send_cmd(input logic [5:0] idx, input logic [31:0] arg);
    logic [47:0] fr;
    fr = {2'b01, idx, arg, 7'h55, 1'b1};
    for (int i = 47; i >= 0; i--)
    begin
      cmd_out = fr[i];
      tick();
    end
    cmd_out = 1'b1;
  endtask

  task automatic send_data(input logic [7:0] d[$], input logic four);
    dat_en_out = four ? 4'hf : 4'h1;
    dat_out    = 4'h0;
    tick();
    foreach (d[i])
      if (four)
      begin
        dat_out = d[i][7:4];
        tick();
        dat_out = d[i][3:0];
        tick();
      end
      else
        for (int b = 7; b >= 0; b--)
        begin
          dat_out = {3'h7, d[i][b]};
          tick();
        end
    // Checksum is not checked, so any pattern; end bit high
    for (int k = 0; k < 17; k++)
    begin
      dat_out = (k == 16) ? 4'hf : 4'(k * 5);
      tick();
    end
    dat_en_out = 4'h0;
    dat_out    = 4'hf;
  endtask

  task automatic spi_cmd(input logic [31:0] arg);
    dat_en_out = 4'h8;
    dat_out    = 4'h7;
    for (int i = 31; i >= 0; i--)
    begin
      cmd_out = arg[i];
      tick();
    end
    #40 dat_en_out = 4'h0;
    dat_out = 4'hf;
    cmd_out = 1'b1;
  endtask
endmodule
